// File: src/port2_pkg.sv
// Purpose: types used by the port-2 block and its assertions
// Assumes: constants live in port2_regs.svh
// Notes: the whole module state is one packed struct
`default_nettype none
package port2_pkg;

    typedef struct packed {
        logic half;
        logic sel1;
        logic sel0;
        logic mbz;
        logic en;
        logic [1:0] speed;
    } cfg_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] idx;
    } phase_type;

    typedef enum logic [1:0] {
        PAIR_NONE,
        PAIR_ZERO,
        PAIR_ONE
    } pair_type;

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        cfg_type cfg;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic half_phase;
        logic [9:0] div_cnt;
        logic tick;
        phase_type ph;
        logic [31:0] rdata;
    } state_type;

endpackage
`default_nettype wire

// File: src/port2_regs.svh
// Purpose: offsets, field positions, reset values and rate counts
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef PORT2_REGS_SVH
`define PORT2_REGS_SVH

`define PORT_IDX_LEVELS 8'h02
`define PORT_IDX_DIR 8'hf6
`define PORT_IDX_CFG 8'h0d

`define PORT_DIR_RESET 8'hff
`define PORT_LATCH_RESET 8'h00
`define PORT_CFG_FIXED_ONE 8'h40

`define CFG_HALF_BIT 7
`define CFG_ONE_BIT 6
`define CFG_SEL1_BIT 5
`define CFG_SEL0_BIT 4
`define CFG_MBZ_BIT 3
`define CFG_EN_BIT 2

`define PAIR0_CLK_LINE 4
`define PAIR0_DAT_LINE 5
`define PAIR1_CLK_LINE 6
`define PAIR1_DAT_LINE 7

`define TW_XTAL_HZ 6000000
`define TW_RATE0_HZ 10000
`define TW_RATE1_HZ 50000
`define TW_RATE2_HZ 100000
`define TW_RATE3_HZ 330000
`define TW_DIV0 (`TW_XTAL_HZ / `TW_RATE0_HZ)
`define TW_DIV1 (`TW_XTAL_HZ / `TW_RATE1_HZ)
`define TW_DIV2 (`TW_XTAL_HZ / `TW_RATE2_HZ)
`define TW_DIV3 (`TW_XTAL_HZ / `TW_RATE3_HZ)

`endif

// File: src/port2_twowire_pin_select.sv
// Purpose: eight-line port with direction control and two-wire pin
//     routing, plus the two-wire clock, enable and bit-rate setup
// Assumes: AHB-Lite slave, single word transfers, no wait states
// Notes: the serial engine itself sits outside and drives lines low
//
// Contract
// - a direction bit of 0 makes its line an output, 1 an input.
// - the direction register is write-only and resets to all ones.
// - select bit 5 puts serial clock 1 on line 6 and data 1 on line 7.
// - select bit 4 puts serial clock 0 on line 4 and data 0 on line 5.
// - with both select bits set only the interface-0 choice is used.
// - lines handed to a serial interface become open-drain by themselves.
// - config bit 7 feeds the serial clock at full or at half rate.
// - config bit 2 disables or enables the two-wire interface.
// - speed bits 1:0 give 10, 50, 100 or 330 kHz for a 6 MHz source.
// - reading the data register gives the line levels, writing sets drive.
`include "port2_regs.svh"
`default_nettype none

module port2_twowire_pin_select (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    input wire logic twi_scl_drive_low,
    input wire logic twi_sda_drive_low,
    output logic twi_scl_level,
    output logic twi_sda_level,
    output logic twi_enable,
    output logic twi_src_clk_en,
    output logic twi_bit_tick
);

    port2_pkg::state_type st_q;
    port2_pkg::state_type st_d;
    port2_pkg::pair_type pair;
    logic addr_take;
    logic mapped;
    logic src_en;
    logic [9:0] div_load;
    logic [7:0] cfg_view;
    logic [7:0] rd_byte;
    logic scl_lo;
    logic sda_lo;

    // zero wait states: every transfer finishes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_q.rdata;

    assign addr_take = hsel && htrans[1] && hready;
    // decode only the low window so far addresses answer as unmapped
    assign mapped = (haddr[31:10] == 22'h000000);

    // pair 0 wins when both select bits are set
    always_comb begin
        if (st_q.cfg.sel0) begin
            pair = port2_pkg::PAIR_ZERO;
        end else if (st_q.cfg.sel1) begin
            pair = port2_pkg::PAIR_ONE;
        end else begin
            pair = port2_pkg::PAIR_NONE;
        end
    end

    // bit-rate reload value per speed code
    always_comb begin
        unique case (st_q.cfg.speed)
            2'b00: div_load = 10'(`TW_DIV0 - 1);
            2'b01: div_load = 10'(`TW_DIV1 - 1);
            2'b10: div_load = 10'(`TW_DIV2 - 1);
            2'b11: div_load = 10'(`TW_DIV3 - 1);
        endcase
    end

    // half rate lets every other system edge through
    assign src_en = st_q.cfg.half ? st_q.half_phase : 1'b1;

    // a read right after a config write sees the new value
    always_comb begin
        if (st_q.ph.valid && st_q.ph.write &&
            st_q.ph.idx == `PORT_IDX_CFG) begin
            cfg_view = hwdata[7:0];
        end else begin
            cfg_view = {st_q.cfg.half, 1'b0, st_q.cfg.sel1,
                st_q.cfg.sel0, st_q.cfg.mbz, st_q.cfg.en,
                st_q.cfg.speed};
        end
        cfg_view[`CFG_ONE_BIT] = 1'b1;
    end

    always_comb begin
        rd_byte = 8'h00;
        if (mapped && haddr[9:2] == `PORT_IDX_LEVELS) begin
            rd_byte = st_q.sync2;
        end else if (mapped && haddr[9:2] == `PORT_IDX_CFG) begin
            rd_byte = cfg_view;
        end
        // the direction register is write-only and reads as zero
    end

    always_comb begin
        st_d = st_q;
        st_d.sync1 = pin_in;
        st_d.sync2 = st_q.sync1;
        st_d.tick = 1'b0;
        st_d.half_phase = ~st_q.half_phase;

        if (st_q.ph.valid && st_q.ph.write) begin
            if (st_q.ph.idx == `PORT_IDX_LEVELS) begin
                st_d.latch = hwdata[7:0];
            end else if (st_q.ph.idx == `PORT_IDX_DIR) begin
                st_d.dir = hwdata[7:0];
            end else if (st_q.ph.idx == `PORT_IDX_CFG) begin
                st_d.cfg.half = hwdata[`CFG_HALF_BIT];
                st_d.cfg.sel1 = hwdata[`CFG_SEL1_BIT];
                st_d.cfg.sel0 = hwdata[`CFG_SEL0_BIT];
                st_d.cfg.mbz = hwdata[`CFG_MBZ_BIT];
                st_d.cfg.en = hwdata[`CFG_EN_BIT];
                st_d.cfg.speed = hwdata[1:0];
            end
        end

        st_d.ph.valid = addr_take && mapped;
        st_d.ph.write = hwrite;
        st_d.ph.idx = haddr[9:2];
        if (addr_take && !hwrite) begin
            st_d.rdata = {24'h000000, rd_byte};
        end

        // a new speed code is taken at the next reload
        if (!st_q.cfg.en) begin
            st_d.div_cnt = div_load;
        end else if (src_en) begin
            if (st_q.div_cnt == 10'h000) begin
                st_d.div_cnt = div_load;
                st_d.tick = 1'b1;
            end else begin
                st_d.div_cnt = st_q.div_cnt - 10'h001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
            st_q.dir <= `PORT_DIR_RESET;
            st_q.latch <= `PORT_LATCH_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign twi_enable = st_q.cfg.en;
    assign twi_src_clk_en = src_en;
    assign twi_bit_tick = st_q.tick;
    assign scl_lo = twi_scl_drive_low && st_q.cfg.en;
    assign sda_lo = twi_sda_drive_low && st_q.cfg.en;

    // ordinary lines follow the direction and latch registers; a
    // handed-over pair only ever pulls low, so a stuck-high peer is safe
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_oe[i] = ~st_q.dir[i];
            pin_out[i] = st_q.latch[i];
        end
        twi_scl_level = 1'b1;
        twi_sda_level = 1'b1;
        unique case (pair)
            port2_pkg::PAIR_ZERO: begin
                pin_out[`PAIR0_CLK_LINE] = 1'b0;
                pin_out[`PAIR0_DAT_LINE] = 1'b0;
                pin_oe[`PAIR0_CLK_LINE] = scl_lo;
                pin_oe[`PAIR0_DAT_LINE] = sda_lo;
                twi_scl_level = st_q.sync2[`PAIR0_CLK_LINE];
                twi_sda_level = st_q.sync2[`PAIR0_DAT_LINE];
            end
            port2_pkg::PAIR_ONE: begin
                pin_out[`PAIR1_CLK_LINE] = 1'b0;
                pin_out[`PAIR1_DAT_LINE] = 1'b0;
                pin_oe[`PAIR1_CLK_LINE] = scl_lo;
                pin_oe[`PAIR1_DAT_LINE] = sda_lo;
                twi_scl_level = st_q.sync2[`PAIR1_CLK_LINE];
                twi_sda_level = st_q.sync2[`PAIR1_DAT_LINE];
            end
            port2_pkg::PAIR_NONE: begin
                twi_scl_level = 1'b1;
            end
            default: begin
                twi_sda_level = 1'b1;
            end
        endcase
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic rd_dir;
    logic rd_lvl;
    logic rd_cfg;
    assign rd_dir = addr_take && mapped && !hwrite &&
        haddr[9:2] == `PORT_IDX_DIR;
    assign rd_lvl = addr_take && mapped && !hwrite &&
        haddr[9:2] == `PORT_IDX_LEVELS;
    assign rd_cfg = addr_take && mapped && !hwrite &&
        haddr[9:2] == `PORT_IDX_CFG;

    AST_DIR_WRITE: assert property (
        st_q.ph.valid && st_q.ph.write && st_q.ph.idx == `PORT_IDX_DIR
        |=> st_q.dir == $past(hwdata[7:0]))
        else $error("direction write not stored");

    AST_LOW_LINES_FOLLOW_DIR: assert property (
        pin_oe[3:0] == ~st_q.dir[3:0] && pin_out[3:0] == st_q.latch[3:0])
        else $error("lines 0 to 3 not steered by direction");

    AST_DIR_READS_ZERO: assert property (
        rd_dir |=> hrdata == 32'h00000000)
        else $error("direction register read not zero");

    AST_PAIR1_ROUTE: assert property (
        st_q.cfg.sel1 && !st_q.cfg.sel0
        |-> pin_oe[7:6] == {sda_lo, scl_lo})
        else $error("pair 1 not routed to lines 6 and 7");

    AST_PAIR0_ROUTE: assert property (
        st_q.cfg.sel0 |-> pin_oe[5:4] == {sda_lo, scl_lo} &&
        twi_scl_level == st_q.sync2[4])
        else $error("pair 0 not routed to lines 4 and 5");

    AST_PAIR0_WINS: assert property (
        st_q.cfg.sel0 && st_q.cfg.sel1
        |-> pin_oe[7:6] == ~st_q.dir[7:6] &&
        pin_out[7:6] == st_q.latch[7:6])
        else $error("lines 6 and 7 taken despite pair 0 select");

    AST_OPEN_DRAIN: assert property (
        st_q.cfg.sel0 |-> pin_out[5:4] == 2'b00)
        else $error("serial line driven high");

    AST_DISABLED_NO_TICK: assert property (
        !st_q.cfg.en ##1 !st_q.cfg.en |-> !twi_bit_tick)
        else $error("bit tick while disabled");

    AST_TICK_SPACING: assert property (
        twi_bit_tick |=> !twi_bit_tick [*8])
        else $error("bit ticks too close");

    AST_HALF_RATE: assert property (
        st_q.cfg.half && twi_src_clk_en ##1 st_q.cfg.half
        |-> !twi_src_clk_en)
        else $error("half rate source enable not halved");

    AST_CFG_BIT6_ONE: assert property (
        rd_cfg |=> hrdata[6] && hrdata[31:8] == 24'h000000)
        else $error("config bit 6 not read as one");

    AST_LEVEL_READ: assert property (
        rd_lvl |=> hrdata[7:0] == $past(st_q.sync2))
        else $error("data read not the line levels");

    // data-phase strobes, one per register, for the write checks
    logic wr_dir;
    logic wr_lvl;
    logic wr_cfg;
    assign wr_dir = st_q.ph.valid && st_q.ph.write &&
        st_q.ph.idx == `PORT_IDX_DIR;
    assign wr_lvl = st_q.ph.valid && st_q.ph.write &&
        st_q.ph.idx == `PORT_IDX_LEVELS;
    assign wr_cfg = st_q.ph.valid && st_q.ph.write &&
        st_q.ph.idx == `PORT_IDX_CFG;

    AST_DIR_HOLDS: assert property (
        !wr_dir |=> $stable(st_q.dir))
        else $error("direction changed without a write");

    AST_LATCH_WRITE: assert property (
        wr_lvl |=> st_q.latch == $past(hwdata[7:0]))
        else $error("data write not stored in the latch");

    AST_CFG_WRITE: assert property (
        wr_cfg |=> st_q.cfg.en == $past(hwdata[`CFG_EN_BIT]) &&
        st_q.cfg.half == $past(hwdata[`CFG_HALF_BIT]) &&
        st_q.cfg.speed == $past(hwdata[1:0]))
        else $error("config write not stored");

    AST_NO_PAIR_LINES: assert property (
        !st_q.cfg.sel0 && !st_q.cfg.sel1
        |-> pin_oe == ~st_q.dir && pin_out == st_q.latch &&
        twi_scl_level && twi_sda_level)
        else $error("lines taken with no pair selected");

    AST_PAIR0_DATA_LEVEL: assert property (
        st_q.cfg.sel0 |-> twi_sda_level == st_q.sync2[5])
        else $error("pair 0 data level not from line 5");

    AST_PAIR0_SPARES: assert property (
        st_q.cfg.sel0 |-> pin_oe[7:6] == ~st_q.dir[7:6] &&
        pin_out[7:6] == st_q.latch[7:6])
        else $error("lines 6 and 7 disturbed by pair 0");

    AST_PAIR1_LEVEL: assert property (
        st_q.cfg.sel1 && !st_q.cfg.sel0
        |-> twi_scl_level == st_q.sync2[6] &&
        twi_sda_level == st_q.sync2[7])
        else $error("pair 1 levels not from lines 6 and 7");

    AST_PAIR1_SPARES: assert property (
        st_q.cfg.sel1 && !st_q.cfg.sel0
        |-> pin_oe[5:4] == ~st_q.dir[5:4] &&
        pin_out[5:4] == st_q.latch[5:4])
        else $error("lines 4 and 5 disturbed by pair 1");

    AST_PAIR1_OPEN_DRAIN: assert property (
        st_q.cfg.sel1 && !st_q.cfg.sel0 |-> pin_out[7:6] == 2'b00)
        else $error("pair 1 line driven high");

    AST_DISABLED_PAIR0_QUIET: assert property (
        !st_q.cfg.en && st_q.cfg.sel0 |-> pin_oe[5:4] == 2'b00)
        else $error("pair 0 pulled low while disabled");

    AST_DISABLED_PAIR1_QUIET: assert property (
        !st_q.cfg.en && st_q.cfg.sel1 && !st_q.cfg.sel0
        |-> pin_oe[7:6] == 2'b00)
        else $error("pair 1 pulled low while disabled");

    AST_FULL_RATE: assert property (
        !st_q.cfg.half |-> twi_src_clk_en)
        else $error("full rate source enable dropped");

    AST_TICK_FROM_SOURCE: assert property (
        twi_bit_tick |-> $past(twi_src_clk_en))
        else $error("bit tick without a source enable");

    AST_RDATA_HOLDS: assert property (
        !(addr_take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");

    COV_TICK: cover property (twi_bit_tick);
    COV_PAIR0_LOW: cover property (st_q.cfg.sel0 && pin_oe[4]);
    COV_PAIR1_LOW: cover property (pair == port2_pkg::PAIR_ONE &&
        pin_oe[7]);
    COV_CFG_READ: cover property (rd_cfg);
    COV_BOTH_SELECT: cover property (st_q.cfg.sel0 && st_q.cfg.sel1);

endmodule
`default_nettype wire

// File: tb/pin_partner.sv
// Purpose: outside world of port 2, pull-ups and bus devices
// Assumes: every line carries a pull-up resistor
// Notes: a device on a line may only pull it low
`default_nettype none
module pin_partner (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_low,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released line floats up to the pull-up level
    assign pin_in = ~ext_low & (pin_out | ~pin_oe);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: self-checking bench for the port-2 pin select block
// Assumes: no-wait AHB-Lite slave, pulled-up lines outside
// Notes: the bench plays bus master and serial engine
`include "port2_regs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hwrite, scl_low, sda_low;
    logic hreadyout, hresp, lvl_scl, lvl_sda, en, src_en, tick;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] pin_in, pin_out, pin_oe, ext_low;
    int err_total = 0;
    int cmp_count = 0;

    port2_twowire_pin_select port2_twowire_pin_select_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe),
        .twi_scl_drive_low(scl_low), .twi_sda_drive_low(sda_low),
        .twi_scl_level(lvl_scl), .twi_sda_level(lvl_sda),
        .twi_enable(en), .twi_src_clk_en(src_en), .twi_bit_tick(tick));
    pin_partner pin_partner_i (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_low(ext_low), .pin_in(pin_in));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [31:0] wd);
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic test_reset;
        check({24'h0, pin_oe}, {24'h0, ~`PORT_DIR_RESET});
        check({24'h0, pin_out}, {24'h0, `PORT_LATCH_RESET});
        check({30'h0, lvl_scl, lvl_sda}, 32'h3);
        xfer(1'b0, `PORT_IDX_DIR, 32'h0);
        check(rd, 32'h0);
        xfer(1'b0, `PORT_IDX_CFG, 32'h0);
        check(rd, {24'h0, `PORT_CFG_FIXED_ONE});
        xfer(1'b1, `PORT_IDX_CFG, 32'h83);
        xfer(1'b0, `PORT_IDX_CFG, 32'h0);
        check(rd, 32'hc3);
        xfer(1'b0, 8'h55, 32'h0);
        check(rd, 32'h0);
        $display("reset and config test done");
    endtask

    task automatic test_port;
        xfer(1'b1, `PORT_IDX_DIR, 32'hf0);
        xfer(1'b1, `PORT_IDX_LEVELS, 32'ha5);
        ext_low <= 8'h30;
        repeat (3) @(posedge hclk);
        check({24'h0, pin_oe}, 32'h0f);
        check({24'h0, pin_out & 8'h0f}, 32'h05);
        xfer(1'b0, `PORT_IDX_LEVELS, 32'h0);
        check(rd, 32'hc5);
        ext_low <= 8'h00;
        $display("port test done");
    endtask

    task automatic test_select;
        logic [7:0] cv[5] = '{8'h14, 8'h24, 8'h34, 8'h10, 8'h24};
        logic [7:0] oe[5] = '{8'hdf, 8'h7f, 8'hdf, 8'hcf, 8'hff};
        logic [7:0] ov[5] = '{8'hcf, 8'h3f, 8'hcf, 8'hcf, 8'h3f};
        logic [1:0] lv[5] = '{2'b01, 2'b01, 2'b01, 2'b11, 2'b00};
        xfer(1'b1, `PORT_IDX_DIR, 32'h00);
        xfer(1'b1, `PORT_IDX_LEVELS, 32'hff);
        scl_low <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            sda_low <= (i == 4);
            xfer(1'b1, `PORT_IDX_CFG, {24'h0, cv[i]});
            repeat (4) @(posedge hclk);
            check({24'h0, pin_oe}, {24'h0, oe[i]});
            check({24'h0, pin_out}, {24'h0, ov[i]});
            check({30'h0, lvl_scl, lvl_sda}, {30'h0, lv[i]});
            check({31'h0, en}, {31'h0, cv[i][2]});
        end
        scl_low <= 1'b0;
        sda_low <= 1'b0;
        $display("select test done");
    endtask

    task automatic period(output int p);
        repeat (2) begin
            p = 0;
            do begin
                @(posedge hclk);
                p++;
            end while (tick !== 1'b1 && p < 2000);
        end
    endtask

    task automatic test_rate;
        int per[4] = '{600, 120, 60, 18};
        int p;
        logic a;
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, `PORT_IDX_CFG, 32'h04 | s);
            period(p);
            check(p, per[s]);
            check({31'h0, src_en}, 32'h1);
        end
        xfer(1'b1, `PORT_IDX_CFG, 32'h87);
        period(p);
        check(p, 36);
        a = src_en;
        @(posedge hclk);
        check({31'h0, a ^ src_en}, 32'h1);
        xfer(1'b1, `PORT_IDX_CFG, 32'h03);
        period(p);
        check(p, 2000);
        $display("rate test done");
    endtask

    initial begin
        hresetn <= 1'b0;
        htrans <= 2'b00;
        haddr <= 32'h0;
        hwrite <= 1'b0;
        hwdata <= 32'h0;
        scl_low <= 1'b0;
        sda_low <= 1'b0;
        ext_low <= 8'h00;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset();
        test_port();
        test_select();
        test_rate();
        complete_run();
    end

    // the whole run needs about 6300 cycles
    initial begin
        #200us;
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
